// [rtl/cursor_key_pkg.sv]
// Constants of the cursor and color-key control register bank.
// Assumes an 8-bit host register port with a 4-bit direct address.
// Behaviour
// - A read/write direct cursor control register sits at direct address 1001 and resets to 0x00.
// - Its two low bits turn the cursor off at 00, pick three-color at 01 and two other formats.
// - A select bit in the indirect cursor control register picks direct (1) or indirect (0).
// - Four byte registers at direct addresses 1100 to 1111 hold X low, X high, Y low and Y high.
// - Each coordinate is 12 bits and the upper nibble of each high byte reads as zero.
// - The coordinates mark the cursor's lower-right corner and may be accessed at any time.
// - A zero X or Y coordinate puts the cursor off screen so no cursor pixel shows.
// - A read/write color-key control register sits at index 0x38 and resets to 0x00.
// - Bits 7 to 5 pick zoom 1x to 32x and the pixel multiplier loads at the reduced rate.
// - Zoom applies only to wide pixel port data and never to the legacy VGA path.
// - Bit 4 selects the true (0) or complemented (1) color-key result.
// - Bits 3 to 0 enable the blue, green, red and overlay comparisons, all off at reset.
// - Each compared field has a low and a high range register at indexes 0x30 to 0x37.
package cursor_key_pkg;
  // ----------------------------------------
  // Direct register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_INDEX = 4'h0;
  localparam logic [3:0] ADDR_CURSOR_MODE_DIRECT = 4'h9;
  localparam logic [3:0] ADDR_INDEXED_DATA = 4'hA;
  localparam logic [3:0] ADDR_CURSOR_X_LOW = 4'hC;
  localparam logic [3:0] ADDR_CURSOR_X_HIGH = 4'hD;
  localparam logic [3:0] ADDR_CURSOR_Y_LOW = 4'hE;
  localparam logic [3:0] ADDR_CURSOR_Y_HIGH = 4'hF;
  // ----------------------------------------
  // Indirect register map
  // ----------------------------------------
  localparam logic [7:0] IDX_CURSOR_CTRL = 8'h06;
  localparam logic [7:0] IDX_KEY_RANGE_BASE = 8'h30;
  localparam logic [7:0] IDX_KEY_RANGE_LAST = 8'h37;
  localparam logic [7:0] IDX_KEY_ZOOM_CONTROL = 8'h38;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CURSOR_SRC_SEL_BIT = 7;
  localparam int ZOOM_MSB = 7;
  localparam int ZOOM_LSB = 5;
  localparam int KEY_POLARITY_BIT = 4;
  localparam int BLUE_EN_BIT = 3;
  localparam int GREEN_EN_BIT = 2;
  localparam int RED_EN_BIT = 1;
  localparam int OVERLAY_EN_BIT = 0;
  localparam logic [2:0] ZOOM_CODE_MAX = 3'h5;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CURSOR_MODE_DIRECT = 8'h00;
  localparam logic [7:0] RST_CURSOR_CTRL = 8'h00;
  localparam logic [7:0] RST_KEY_ZOOM_CONTROL = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [7:0] RST_KEY_RANGE = 8'h00;
  localparam logic [11:0] RST_COORD = 12'h000;
  localparam logic [7:0] READ_NONE = 8'h00;

  typedef enum logic [1:0]
  {
    CURSOR_OFF = 2'b00,
    CURSOR_THREE_COLOR = 2'b01,
    CURSOR_FORMAT_A = 2'b10,
    CURSOR_FORMAT_B = 2'b11
  } cursor_mode_t;
endpackage

// [rtl/coord_if.sv]
// Write strobes and stored value of one cursor coordinate.
// Assumes the register bank drives strobes for one clock cycle.
`timescale 1ns/100ps
interface coord_if;
  logic wr_low;
  logic wr_high;
  logic [7:0] wdata;
  logic [11:0] coord;

  modport bank(output wr_low, output wr_high, output wdata, input coord);
  modport store(input wr_low, input wr_high, input wdata, output coord);
endinterface

// [rtl/cursor_coord_reg.sv]
// One 12-bit cursor coordinate written as a low and a high byte.
// Assumes strobes arrive from the register bank on clk_sys.
`timescale 1ns/100ps
module cursor_coord_reg
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Bank side
  coord_if.store bus
);
  logic [11:0] coord_q;
  logic [11:0] coord_d;

  assign coord_d = bus.wr_low ? {coord_q[11:8], bus.wdata} :
                   bus.wr_high ? {bus.wdata[3:0], coord_q[7:0]} : coord_q;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      coord_q <= cursor_key_pkg::RST_COORD;
    else
      coord_q <= coord_d;
  end

  assign bus.coord = coord_q;

  a_low_byte_store: assert property (@(posedge clk_sys) disable iff (reset)
    bus.wr_low |=> coord_q[7:0] == $past(bus.wdata))
    else $error("coordinate low byte not stored");
  a_high_nibble_store: assert property (@(posedge clk_sys) disable iff (reset)
    bus.wr_high && !bus.wr_low |=> coord_q[11:8] == $past(bus.wdata[3:0]))
    else $error("coordinate high nibble not stored");
endmodule

// [rtl/cursor_colorkey_control_regs.sv]
// Cursor mode, cursor position and color-key control register bank.
// Assumes a host port whose read and write strobes last one clk_sys cycle.
`timescale 1ns/100ps
module cursor_colorkey_control_regs
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Host register port
  input wire logic [3:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  // Pixel path select
  input wire logic vga_path_sel,
  // Cursor controls
  output logic [1:0] cursor_mode,
  output logic cursor_visible,
  output logic [11:0] cursor_x_coord,
  output logic [11:0] cursor_y_coord,
  // Color-key and zoom controls
  output logic [2:0] pixel_load_shift,
  output logic key_polarity_bit,
  output logic blue_compare_enable,
  output logic green_compare_enable,
  output logic red_compare_enable,
  output logic overlay_compare_enable,
  output logic [63:0] key_ranges
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] index_q;
  logic [1:0] cursor_mode_field_q;
  logic [7:0] cursor_ctrl_q;
  logic [7:0] key_zoom_control_q;
  logic [7:0] key_range_q [0:7];
  logic [1:0] cursor_mode_q;
  logic cursor_visible_q;
  logic [2:0] pixel_load_shift_q;
  logic [7:0] cpu_rdata_q;
  logic cpu_rvalid_q;

  coord_if x_bus ();
  coord_if y_bus ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire wr_index = cpu_wr && (cpu_addr == cursor_key_pkg::ADDR_INDEX);
  wire wr_mode_direct = cpu_wr && (cpu_addr == cursor_key_pkg::ADDR_CURSOR_MODE_DIRECT);
  wire wr_indexed = cpu_wr && (cpu_addr == cursor_key_pkg::ADDR_INDEXED_DATA);
  wire wr_cursor_ctrl = wr_indexed && (index_q == cursor_key_pkg::IDX_CURSOR_CTRL);
  wire wr_key_zoom = wr_indexed && (index_q == cursor_key_pkg::IDX_KEY_ZOOM_CONTROL);
  wire idx_in_range = (index_q >= cursor_key_pkg::IDX_KEY_RANGE_BASE) &&
                      (index_q <= cursor_key_pkg::IDX_KEY_RANGE_LAST);
  wire [2:0] range_sel = index_q[2:0];
  wire wr_key_range = wr_indexed && idx_in_range;

  assign x_bus.wr_low = cpu_wr && (cpu_addr == cursor_key_pkg::ADDR_CURSOR_X_LOW);
  assign x_bus.wr_high = cpu_wr && (cpu_addr == cursor_key_pkg::ADDR_CURSOR_X_HIGH);
  assign x_bus.wdata = cpu_wdata;
  assign y_bus.wr_low = cpu_wr && (cpu_addr == cursor_key_pkg::ADDR_CURSOR_Y_LOW);
  assign y_bus.wr_high = cpu_wr && (cpu_addr == cursor_key_pkg::ADDR_CURSOR_Y_HIGH);
  assign y_bus.wdata = cpu_wdata;

  cursor_coord_reg u_coord_x
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus(x_bus)
  );

  cursor_coord_reg u_coord_y
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus(y_bus)
  );

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      index_q <= cursor_key_pkg::RST_INDEX;
    else if (wr_index)
      index_q <= cpu_wdata;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      cursor_mode_field_q <= cursor_key_pkg::RST_CURSOR_MODE_DIRECT[1:0];
    else if (wr_mode_direct)
      cursor_mode_field_q <= cpu_wdata[1:0];
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      cursor_ctrl_q <= cursor_key_pkg::RST_CURSOR_CTRL;
    else if (wr_cursor_ctrl)
      cursor_ctrl_q <= cpu_wdata;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      key_zoom_control_q <= cursor_key_pkg::RST_KEY_ZOOM_CONTROL;
    else if (wr_key_zoom)
      key_zoom_control_q <= cpu_wdata;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_range
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
          key_range_q[g] <= cursor_key_pkg::RST_KEY_RANGE;
        else if (wr_key_range && (range_sel == 3'(g)))
          key_range_q[g] <= cpu_wdata;
      end
      assign key_ranges[g*8 +: 8] = key_range_q[g];
    end
  endgenerate

  // ----------------------------------------
  // Derived cursor and zoom state
  // ----------------------------------------
  // Mode source select
  wire use_direct = cursor_ctrl_q[cursor_key_pkg::CURSOR_SRC_SEL_BIT];
  wire [1:0] mode_d = use_direct ? cursor_mode_field_q : cursor_ctrl_q[1:0];
  wire coord_zero = (x_bus.coord == 12'h000) || (y_bus.coord == 12'h000);
  wire visible_d = (mode_d != cursor_key_pkg::CURSOR_OFF) && !coord_zero;
  wire [2:0] zoom_factor_field = key_zoom_control_q[cursor_key_pkg::ZOOM_MSB:
                                                    cursor_key_pkg::ZOOM_LSB];
  wire [2:0] zoom_shift = (zoom_factor_field > cursor_key_pkg::ZOOM_CODE_MAX) ?
                          3'h0 : zoom_factor_field;
  wire [2:0] shift_d = vga_path_sel ? 3'h0 : zoom_shift;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cursor_mode_q <= cursor_key_pkg::CURSOR_OFF;
      cursor_visible_q <= 1'b0;
      pixel_load_shift_q <= 3'h0;
    end
    else
    begin
      cursor_mode_q <= mode_d;
      cursor_visible_q <= visible_d;
      pixel_load_shift_q <= shift_d;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Reserved bits read as zero
  wire [7:0] rd_mode_direct = {6'h00, cursor_mode_field_q};
  wire [7:0] rd_x_high = {4'h0, x_bus.coord[11:8]};
  wire [7:0] rd_y_high = {4'h0, y_bus.coord[11:8]};
  wire [7:0] rd_indexed = (index_q == cursor_key_pkg::IDX_CURSOR_CTRL) ? cursor_ctrl_q :
                          (index_q == cursor_key_pkg::IDX_KEY_ZOOM_CONTROL) ?
                          key_zoom_control_q :
                          idx_in_range ? key_range_q[range_sel] : cursor_key_pkg::READ_NONE;
  wire [7:0] rd_mux = (cpu_addr == cursor_key_pkg::ADDR_INDEX) ? index_q :
                      (cpu_addr == cursor_key_pkg::ADDR_CURSOR_MODE_DIRECT) ? rd_mode_direct :
                      (cpu_addr == cursor_key_pkg::ADDR_INDEXED_DATA) ? rd_indexed :
                      (cpu_addr == cursor_key_pkg::ADDR_CURSOR_X_LOW) ? x_bus.coord[7:0] :
                      (cpu_addr == cursor_key_pkg::ADDR_CURSOR_X_HIGH) ? rd_x_high :
                      (cpu_addr == cursor_key_pkg::ADDR_CURSOR_Y_LOW) ? y_bus.coord[7:0] :
                      (cpu_addr == cursor_key_pkg::ADDR_CURSOR_Y_HIGH) ? rd_y_high :
                      cursor_key_pkg::READ_NONE;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cpu_rdata_q <= cursor_key_pkg::READ_NONE;
      cpu_rvalid_q <= 1'b0;
    end
    else
    begin
      cpu_rvalid_q <= cpu_rd;
      if (cpu_rd)
        cpu_rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cpu_rdata = cpu_rdata_q;
  assign cpu_rvalid = cpu_rvalid_q;
  assign cursor_mode = cursor_mode_q;
  assign cursor_visible = cursor_visible_q;
  assign cursor_x_coord = x_bus.coord;
  assign cursor_y_coord = y_bus.coord;
  assign pixel_load_shift = pixel_load_shift_q;
  assign key_polarity_bit = key_zoom_control_q[cursor_key_pkg::KEY_POLARITY_BIT];
  assign blue_compare_enable = key_zoom_control_q[cursor_key_pkg::BLUE_EN_BIT];
  assign green_compare_enable = key_zoom_control_q[cursor_key_pkg::GREEN_EN_BIT];
  assign red_compare_enable = key_zoom_control_q[cursor_key_pkg::RED_EN_BIT];
  assign overlay_compare_enable = key_zoom_control_q[cursor_key_pkg::OVERLAY_EN_BIT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_direct_mode_write: assert property (@(posedge clk_sys) disable iff (reset)
    wr_mode_direct && use_direct && !wr_cursor_ctrl |=> ##1
    cursor_mode_q == $past(cpu_wdata[1:0], 2))
    else $error("direct cursor mode not applied");
  a_direct_read: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_rd && cpu_addr == cursor_key_pkg::ADDR_CURSOR_MODE_DIRECT |=> cpu_rdata_q[1:0] == $past(cursor_mode_field_q))
    else $error("direct cursor mode readback wrong");
  a_cursor_ctrl_store: assert property (@(posedge clk_sys) disable iff (reset)
    wr_cursor_ctrl |=> cursor_ctrl_q == $past(cpu_wdata))
    else $error("indirect cursor control not stored");
  a_mode_source: assert property (@(posedge clk_sys) disable iff (reset)
    !use_direct |=> cursor_mode_q == $past(cursor_ctrl_q[1:0]))
    else $error("indirect cursor mode not applied");
  a_mode_off_hidden: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_d == cursor_key_pkg::CURSOR_OFF) |=> !cursor_visible_q)
    else $error("cursor visible while mode is off");
  a_zero_coord_hidden: assert property (@(posedge clk_sys) disable iff (reset)
    (x_bus.coord == 12'h000 || y_bus.coord == 12'h000) |=> !cursor_visible_q)
    else $error("cursor visible with zero coordinate");
  a_visible_when_on: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_d != cursor_key_pkg::CURSOR_OFF) && !coord_zero |=> cursor_visible_q)
    else $error("cursor hidden while on with nonzero position");
  a_x_low_read: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_rd && cpu_addr == cursor_key_pkg::ADDR_CURSOR_X_LOW |=> cpu_rdata_q == $past(x_bus.coord[7:0]))
    else $error("coordinate low byte readback wrong");
  a_rvalid_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> cpu_rvalid_q == $past(cpu_rd))
    else $error("read answer not one cycle after strobe");
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !cpu_rd |=> $stable(cpu_rdata_q))
    else $error("read data changed without a read");
  a_reserved_read_zero: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_rd && cpu_addr == cursor_key_pkg::ADDR_CURSOR_MODE_DIRECT |=>
    cpu_rvalid_q && cpu_rdata_q[7:2] == 6'h00)
    else $error("reserved cursor control bits read nonzero");
  a_high_nibble_read: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_rd && (cpu_addr == cursor_key_pkg::ADDR_CURSOR_X_HIGH ||
    cpu_addr == cursor_key_pkg::ADDR_CURSOR_Y_HIGH) |=> cpu_rdata_q[7:4] == 4'h0)
    else $error("coordinate high nibble nonzero");
  a_zoom_wide_rate: assert property (@(posedge clk_sys) disable iff (reset)
    !vga_path_sel && zoom_factor_field <= 3'h5 |=> pixel_load_shift_q == $past(zoom_factor_field))
    else $error("zoom load rate wrong");
  a_zoom_vga_none: assert property (@(posedge clk_sys) disable iff (reset)
    vga_path_sel |=> pixel_load_shift_q == 3'h0)
    else $error("legacy path zoomed");
  a_zoom_illegal_one: assert property (@(posedge clk_sys) disable iff (reset)
    zoom_factor_field > 3'h5 |=> pixel_load_shift_q == 3'h0)
    else $error("unlisted zoom code not 1x");
  a_key_write_read: assert property (@(posedge clk_sys) disable iff (reset)
    wr_key_zoom ##1 !cpu_wr ##1 (cpu_rd && !cpu_wr &&
    cpu_addr == cursor_key_pkg::ADDR_INDEXED_DATA &&
    index_q == cursor_key_pkg::IDX_KEY_ZOOM_CONTROL) |=> cpu_rdata_q == $past(cpu_wdata, 3))
    else $error("color-key control readback wrong");
  a_index_store: assert property (@(posedge clk_sys) disable iff (reset)
    wr_index |=> index_q == $past(cpu_wdata))
    else $error("index register not stored");
  a_key_zoom_store: assert property (@(posedge clk_sys) disable iff (reset)
    wr_key_zoom |=> key_zoom_control_q == $past(cpu_wdata))
    else $error("color-key control not stored");
  a_polarity_follow: assert property (@(posedge clk_sys) disable iff (reset)
    wr_key_zoom |=> key_polarity_bit == $past(cpu_wdata[cursor_key_pkg::KEY_POLARITY_BIT]))
    else $error("key polarity does not follow write");
  a_enables_follow: assert property (@(posedge clk_sys) disable iff (reset)
    wr_key_zoom |=> {blue_compare_enable, green_compare_enable, red_compare_enable,
    overlay_compare_enable} == $past(cpu_wdata[3:0]))
    else $error("compare enables do not follow write");
  a_range_store: assert property (@(posedge clk_sys) disable iff (reset)
    wr_key_range |=> key_range_q[$past(range_sel)] == $past(cpu_wdata))
    else $error("range register not stored");
  a_enables_reset_off: assert property (@(posedge clk_sys)
    $fell(reset) |-> !blue_compare_enable && !green_compare_enable &&
    !red_compare_enable && !overlay_compare_enable && !key_polarity_bit)
    else $error("compare enables not off after reset");
endmodule

// [sim/host_model.sv]
// Graphics controller model that drives the host register port.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/100ps
module host_model
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [3:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_rvalid
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial
  begin
    cpu_addr = 4'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end

  // Idle address and data show the inverse so stale values never pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    cpu_wr = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q, output logic ok);
    ok = 1'b0;
    q = 8'h00;
    @(posedge clk_sys);
    #1;
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    cpu_rd = 1'b0;
    cpu_addr = ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (cpu_rvalid === 1'b1)
      begin
        q = cpu_rdata;
        ok = 1'b1;
      end
      else
      begin
        @(posedge clk_sys);
        #1;
      end
    end
  endtask

  task automatic put_coord(input logic is_y, input logic [11:0] upper_left);
    logic [11:0] v;
    v = upper_left + 12'h040;
    wr(is_y ? cursor_key_pkg::ADDR_CURSOR_Y_LOW : cursor_key_pkg::ADDR_CURSOR_X_LOW, v[7:0]);
    wr(is_y ? cursor_key_pkg::ADDR_CURSOR_Y_HIGH : cursor_key_pkg::ADDR_CURSOR_X_HIGH,
      {4'h0, v[11:8]});
  endtask

  // Load clock divide is left to the clock source
  task automatic set_key(input logic [2:0] zoom, input logic [4:0] low);
    wr(cursor_key_pkg::ADDR_INDEX, cursor_key_pkg::IDX_KEY_ZOOM_CONTROL);
    wr(cursor_key_pkg::ADDR_INDEXED_DATA, {zoom, low});
  endtask
endmodule

// [sim/tb_cursor_colorkey_control_regs.sv]
// Self-checking bench of the cursor and color-key register bank.
// Assumes host_model drives the register port.
`timescale 1ns/100ps
module tb_cursor_colorkey_control_regs;
  logic clk_sys, reset, vga_path_sel, cpu_wr, cpu_rd, cpu_rvalid;
  logic [3:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, q;
  logic [1:0] cursor_mode;
  logic cursor_visible, key_polarity_bit, blue_compare_enable, green_compare_enable;
  logic red_compare_enable, overlay_compare_enable;
  logic [11:0] cursor_x_coord, cursor_y_coord;
  logic [2:0] pixel_load_shift;
  logic [63:0] key_ranges;
  int err_count = 0;
  int checks_done = 0;

  host_model host (.clk_sys(clk_sys), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid));
  cursor_colorkey_control_regs dut (.clk_sys(clk_sys), .reset(reset), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .vga_path_sel(vga_path_sel), .cursor_mode(cursor_mode),
    .cursor_visible(cursor_visible), .cursor_x_coord(cursor_x_coord),
    .cursor_y_coord(cursor_y_coord), .pixel_load_shift(pixel_load_shift),
    .key_polarity_bit(key_polarity_bit), .blue_compare_enable(blue_compare_enable),
    .green_compare_enable(green_compare_enable), .red_compare_enable(red_compare_enable),
    .overlay_compare_enable(overlay_compare_enable), .key_ranges(key_ranges));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic get(input logic [3:0] a, output logic [7:0] d);
    logic ok;
    host.rd(a, d, ok);
    if (!ok)
    begin
      err_count++;
      $display("BAD read answer expected 1 seen 0");
      end_of_test();
    end
  endtask

  task automatic get_idx(input logic [7:0] idx, output logic [7:0] d);
    host.wr(cursor_key_pkg::ADDR_INDEX, idx);
    get(cursor_key_pkg::ADDR_INDEXED_DATA, d);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    get(cursor_key_pkg::ADDR_CURSOR_MODE_DIRECT, q);
    check("direct mode reset", cursor_key_pkg::RST_CURSOR_MODE_DIRECT, q);
    get_idx(cursor_key_pkg::IDX_KEY_ZOOM_CONTROL, q);
    check("key control reset", 8'h00, q);
    check("polarity reset", 1'b0, key_polarity_bit);
    check("enables reset", 4'h0, {blue_compare_enable, green_compare_enable,
      red_compare_enable, overlay_compare_enable});
    $display("test_reset done");
  endtask

  task automatic test_mode();
    host.wr(cursor_key_pkg::ADDR_INDEX, cursor_key_pkg::IDX_CURSOR_CTRL);
    host.wr(cursor_key_pkg::ADDR_INDEXED_DATA, 8'h03);
    settle();
    check("indirect mode", 2'h3, cursor_mode);
    host.wr(cursor_key_pkg::ADDR_INDEXED_DATA, 8'h80);
    for (int m = 0; m < 4; m++)
    begin
      host.wr(cursor_key_pkg::ADDR_CURSOR_MODE_DIRECT, {6'h3F, m[1:0]});
      get(cursor_key_pkg::ADDR_CURSOR_MODE_DIRECT, q);
      check("direct mode readback", {6'h00, m[1:0]}, q);
      settle();
      check("direct mode out", m[1:0], cursor_mode);
      check("hidden at zero coord", 1'b0, cursor_visible);
    end
    $display("test_mode done");
  endtask

  task automatic test_coord();
    host.put_coord(1'b0, 12'hF00);
    get(cursor_key_pkg::ADDR_CURSOR_X_HIGH, q);
    check("x high", 8'h0F, q);
    host.wr(cursor_key_pkg::ADDR_CURSOR_X_HIGH, 8'hFA);
    get(cursor_key_pkg::ADDR_CURSOR_X_HIGH, q);
    check("x high nibble", 8'h0A, q);
    host.put_coord(1'b1, 12'h010);
    get(cursor_key_pkg::ADDR_CURSOR_Y_LOW, q);
    check("y low", 8'h50, q);
    settle();
    check("x coord", 12'hA40, cursor_x_coord);
    check("y coord", 12'h050, cursor_y_coord);
    check("visible", 1'b1, cursor_visible);
    host.wr(cursor_key_pkg::ADDR_CURSOR_Y_LOW, 8'h00);
    settle();
    check("hidden at zero y", 1'b0, cursor_visible);
    $display("test_coord done");
  endtask

  task automatic test_zoom();
    for (int c = 0; c < 8; c++)
    begin
      host.set_key(c[2:0], 5'h15);
      get(cursor_key_pkg::ADDR_INDEXED_DATA, q);
      check("key control readback", {c[2:0], 5'h15}, q);
      settle();
      check("load shift", (c <= 5) ? c[2:0] : 3'h0, pixel_load_shift);
      check("key bits", 5'h15, {key_polarity_bit, blue_compare_enable, green_compare_enable,
        red_compare_enable, overlay_compare_enable});
    end
    host.set_key(3'h3, 5'h0A);
    vga_path_sel = 1'b1;
    settle();
    check("vga shift", 3'h0, pixel_load_shift);
    vga_path_sel = 1'b0;
    settle();
    check("wide port shift", 3'h3, pixel_load_shift);
    $display("test_zoom done");
  endtask

  task automatic test_ranges();
    for (int g = 0; g < 8; g++)
    begin
      host.wr(cursor_key_pkg::ADDR_INDEX, cursor_key_pkg::IDX_KEY_RANGE_BASE + g[7:0]);
      host.wr(cursor_key_pkg::ADDR_INDEXED_DATA, 8'hA0 + g[7:0]);
    end
    settle();
    check("key ranges", 64'hA7A6A5A4A3A2A1A0, key_ranges);
    get_idx(cursor_key_pkg::IDX_KEY_RANGE_LAST, q);
    check("range readback", 8'hA7, q);
    get(4'h5, q);
    check("unmapped direct", cursor_key_pkg::READ_NONE, q);
    $display("test_ranges done");
  endtask

  initial
  begin
    reset = 1'b1;
    vga_path_sel = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    test_reset();
    test_mode();
    test_coord();
    test_zoom();
    test_ranges();
    end_of_test();
  end
endmodule
